// [rtl/fts_pkg.sv]
// Shared constants, types and stamp helpers for the frame time-stamp counters.
package fts_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned FREE_RATE_HZ = 120_000_000;
  localparam int unsigned NS_PER_S     = 1_000_000_000;
  // Nanoseconds added to the syntonized counter on each clock edge.
  localparam int unsigned NS_PER_CLK   = NS_PER_S / CLK_HZ;
  // Whole free-running counts per clock, plus a fractional remainder carried in a residue.
  localparam int unsigned FREE_INC_MIN = FREE_RATE_HZ / CLK_HZ;
  localparam int unsigned FREE_FRAC    = FREE_RATE_HZ % CLK_HZ;

  // A 32-bit count at the free-running rate wraps after about 35.8 s.
  localparam int unsigned FREE_W  = 32;
  localparam int unsigned SEC_W   = 32;
  localparam int unsigned NS_W    = 32;
  localparam int unsigned STAMP_W = 64;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned CNT_W   = 4;

  localparam logic [CNT_W-1:0] STAMP_BYTES_LONG  = 4'h8;
  localparam logic [CNT_W-1:0] STAMP_BYTES_SHORT = 4'h4;

  typedef enum logic [1:0] {
    FTS_FMT_SEC2_NS30,
    FTS_FMT_SEC32_NS30,
    FTS_FMT_FREE32
  } fts_fmt_t;

  typedef enum logic {
    FTS_RX_PASS,
    FTS_RX_STAMP
  } fts_rx_st_t;

  // Forms a 64-bit frame stamp in the selected format; unused upper bits are zero.
  function automatic logic [STAMP_W-1:0] fts_build_stamp(
    input fts_fmt_t          fmt,
    input logic [SEC_W-1:0]  sec,
    input logic [NS_W-1:0]   ns,
    input logic [FREE_W-1:0] free
  );
    logic [STAMP_W-1:0] s;
    s = '0;
    case (fmt)
      FTS_FMT_SEC2_NS30:  s = {32'h0000_0000, sec[1:0], ns[29:0]};
      FTS_FMT_SEC32_NS30: s = {sec, 2'h0, ns[29:0]};
      FTS_FMT_FREE32:     s = {32'h0000_0000, free};
      default:            s = '0;
    endcase
    return s;
  endfunction : fts_build_stamp

  // Only the seconds-plus-nanoseconds format with full seconds needs eight bytes.
  function automatic logic fts_stamp_long(input fts_fmt_t fmt);
    return fmt == FTS_FMT_SEC32_NS30;
  endfunction : fts_stamp_long

endpackage : fts_pkg

// [rtl/fts_time_if.sv]
// Interface joining the two counters to the time-stamp top.
`timescale 1ns/100ps
interface fts_time_if;
  logic                      run;
  logic                      strobe;
  logic [fts_pkg::NS_W-1:0]   limit;
  logic [fts_pkg::FREE_W-1:0] free;
  logic [fts_pkg::FREE_W-1:0] snapshot;
  logic [fts_pkg::NS_W-1:0]   ns;
  logic [fts_pkg::SEC_W-1:0]  sec;

  modport free_mp (input run, input strobe, output free, output snapshot);
  modport synt_mp (input run, input limit, output ns, output sec);
  modport top_mp  (output run, output strobe, output limit,
                   input free, input snapshot, input ns, input sec);
endinterface : fts_time_if

// [rtl/fts_free_counter.sv]
// Free-running counter at the 120 MHz rate with strobe snapshot.
`timescale 1ns/100ps
module fts_free_counter (
  input wire logic     clock,
  input wire logic     sys_rst,
  fts_time_if.free_mp  tif
);

  typedef struct packed {
    logic [fts_pkg::FREE_W-1:0] free;
    logic [31:0]                resid;
    logic                       strobe_prev;
    logic [fts_pkg::FREE_W-1:0] snap;
  } fts_free_state_t;

  fts_free_state_t q;
  fts_free_state_t d;
  logic [31:0]     sum;

  always_comb begin
    d   = q;
    sum = q.resid + 32'(fts_pkg::FREE_FRAC);
    d.strobe_prev = tif.strobe;
    if (tif.run) begin
      if (sum >= 32'(fts_pkg::CLK_HZ)) begin
        d.resid = sum - 32'(fts_pkg::CLK_HZ);
        d.free  = q.free + 32'(fts_pkg::FREE_INC_MIN) + 32'h0000_0001;
      end else begin
        d.resid = sum;
        d.free  = q.free + 32'(fts_pkg::FREE_INC_MIN);
      end
      if (tif.strobe && !q.strobe_prev) begin
        d.snap = q.free;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.free     = q.free;
  assign tif.snapshot = q.snap;

  property p_free_hold;
    @(posedge clock) disable iff (sys_rst) !tif.run |=> tif.free == $past(tif.free);
  endproperty
  a_free_hold: assert property (p_free_hold) else $error("free counter moved while disabled");

  property p_free_step;
    @(posedge clock) disable iff (sys_rst)
      tif.run |=> (tif.free - $past(tif.free) == 32'h0000_0004)
               || (tif.free - $past(tif.free) == 32'h0000_0005);
  endproperty
  a_free_step: assert property (p_free_step) else $error("free counter step not 4 or 5");

  property p_snap_take;
    @(posedge clock) disable iff (sys_rst)
      tif.run && tif.strobe && !q.strobe_prev |=> tif.snapshot == $past(tif.free);
  endproperty
  a_snap_take: assert property (p_snap_take) else $error("snapshot did not take free count");

  property p_snap_keep;
    @(posedge clock) disable iff (sys_rst)
      !(tif.strobe && !q.strobe_prev) |=> $stable(tif.snapshot);
  endproperty
  a_snap_keep: assert property (p_snap_keep) else $error("snapshot changed without strobe");

endmodule : fts_free_counter

// [rtl/fts_synt_counter.sv]
// Syntonized seconds and nanoseconds counter with programmable rollover.
`timescale 1ns/100ps
module fts_synt_counter (
  input wire logic     clock,
  input wire logic     sys_rst,
  fts_time_if.synt_mp  tif
);

  typedef struct packed {
    logic [fts_pkg::SEC_W-1:0] sec;
    logic [fts_pkg::NS_W-1:0]  ns;
  } fts_synt_state_t;

  fts_synt_state_t q;
  fts_synt_state_t d;

  always_comb begin
    d = q;
    if (tif.run) begin
      if (q.ns >= tif.limit) begin
        d.ns  = '0;
        d.sec = q.sec + 32'h0000_0001;
      end else begin
        d.ns = q.ns + 32'(fts_pkg::NS_PER_CLK);
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.ns  = q.ns;
  assign tif.sec = q.sec;

  property p_ns_roll;
    @(posedge clock) disable iff (sys_rst)
      tif.run && tif.ns >= tif.limit |=> tif.ns == '0 && tif.sec == $past(tif.sec) + 32'h0000_0001;
  endproperty
  a_ns_roll: assert property (p_ns_roll) else $error("nanoseconds did not roll over");

  property p_ns_step;
    @(posedge clock) disable iff (sys_rst)
      tif.run && tif.ns < tif.limit |=> tif.ns == $past(tif.ns) + 32'h0000_0028 && $stable(tif.sec);
  endproperty
  a_ns_step: assert property (p_ns_step) else $error("nanoseconds step wrong");

  property p_synt_hold;
    @(posedge clock) disable iff (sys_rst)
      !tif.run |=> $stable(tif.ns) && $stable(tif.sec);
  endproperty
  a_synt_hold: assert property (p_synt_hold) else $error("syntonized counter moved while disabled");

endmodule : fts_synt_counter

// [rtl/fts_top.sv]
// Frame time-stamp top: counters, receive stamp insertion and transmit stamp capture.
`timescale 1ns/100ps
// Contract
// - Free-running counter advances at 120 MHz rate, 8.333 ns per count.
// - Free-running counter is 32 bits wide, wrapping after roughly 35 s.
// - Free-running counter counts only while the run enable is 1.
// - With counting and frame stamping enabled, each received frame gets a stamp ahead of its data.
// - A transmit stamp is captured only when the host requests one for that frame.
// - Capture strobe copies the current free count into the snapshot while the run enable is 1.
// - Syntonized counter is 64 bits: nanoseconds low, seconds high, 1 ns per LSB.
// - Nanoseconds reaching the rollover limit clear and seconds increment.
// - Syntonized counter also runs only while the run enable is 1.
// - First format records 2-bit seconds and 30-bit nanoseconds.
// - Second format records 32-bit seconds and 30-bit nanoseconds.
// - Third format records the whole 32-bit free-running count.
// - Frame stamps are taken only while the frame stamp enable is 1.
module fts_top (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        counter_run_enable,
  input  wire logic                        frame_stamp_enable,
  input  wire logic [1:0]                  stamp_format,
  input  wire logic [fts_pkg::NS_W-1:0]    nanosecond_rollover_limit,
  input  wire logic                        capture_strobe_input,
  output wire logic [fts_pkg::FREE_W-1:0]  free_count_snapshot,
  output wire logic [fts_pkg::FREE_W-1:0]  free_count,
  output wire logic [fts_pkg::SEC_W-1:0]   synt_seconds,
  output wire logic [fts_pkg::NS_W-1:0]    synt_nanoseconds,
  input  wire logic                        rx_in_valid,
  output wire logic                        rx_in_ready,
  input  wire logic [7:0]                  rx_in_data,
  input  wire logic                        rx_in_first,
  input  wire logic                        rx_in_last,
  output wire logic                        rx_out_valid,
  input  wire logic                        rx_out_ready,
  output wire logic [7:0]                  rx_out_data,
  output wire logic                        rx_out_first,
  output wire logic                        rx_out_last,
  input  wire logic                        tx_frame_start,
  input  wire logic                        tx_stamp_request,
  output wire logic                        tx_stamp_valid,
  output wire logic [fts_pkg::STAMP_W-1:0] tx_stamp,
  input  wire logic                        tx_stamp_ack
);

  typedef struct packed {
    fts_pkg::fts_rx_st_t         st;
    logic                        done;
    logic [fts_pkg::STAMP_W-1:0] sh;
    logic [fts_pkg::CNT_W-1:0]   cnt;
    logic                        ov;
    logic [fts_pkg::BYTE_W-1:0]  od;
    logic                        of;
    logic                        ol;
    logic                        tv;
    logic [fts_pkg::STAMP_W-1:0] ts;
  } fts_top_state_t;

  fts_time_if tif ();

  fts_top_state_t              q;
  fts_top_state_t              d;
  fts_pkg::fts_fmt_t           fmt;
  logic                        stamp_on;
  logic                        can_load;
  logic                        rx_take_stamp;
  logic                        tx_take_stamp;
  logic [fts_pkg::STAMP_W-1:0] stamp_now;
  logic [fts_pkg::STAMP_W-1:0] stamp_aligned;

  assign tif.run    = counter_run_enable;
  assign tif.strobe = capture_strobe_input;
  assign tif.limit  = nanosecond_rollover_limit;

  fts_free_counter u_free (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tif     (tif.free_mp)
  );

  fts_synt_counter u_synt (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tif     (tif.synt_mp)
  );

  assign fmt       = fts_pkg::fts_fmt_t'(stamp_format);
  // Stamps need both the counters running and frame stamping switched on.
  assign stamp_on  = counter_run_enable && frame_stamp_enable;
  assign stamp_now = fts_pkg::fts_build_stamp(fmt, tif.sec, tif.ns, tif.free);
  // Short stamps are moved to the top so bytes always leave from bits 63:56.
  assign stamp_aligned = fts_pkg::fts_stamp_long(fmt) ? stamp_now
                                                      : {stamp_now[31:0], 32'h0000_0000};

  // The output byte register may be reloaded when empty or being taken this cycle.
  assign can_load      = !q.ov || rx_out_ready;
  assign rx_take_stamp = q.st == fts_pkg::FTS_RX_PASS && can_load && rx_in_valid
                         && rx_in_first && stamp_on && !q.done;
  assign tx_take_stamp = tx_frame_start && tx_stamp_request && stamp_on;

  always_comb begin
    d = q;
    if (q.ov && rx_out_ready) begin
      d.ov = 1'b0;
    end
    case (q.st)
      fts_pkg::FTS_RX_PASS: begin
        if (rx_take_stamp) begin
          // The first frame byte is held off while the stamp bytes go out ahead of it.
          d.od  = stamp_aligned[63:56];
          d.sh  = {stamp_aligned[55:0], 8'h00};
          d.cnt = (fts_pkg::fts_stamp_long(fmt) ? fts_pkg::STAMP_BYTES_LONG
                                                : fts_pkg::STAMP_BYTES_SHORT) - 4'h1;
          d.ov  = 1'b1;
          d.of  = 1'b1;
          d.ol  = 1'b0;
          d.st  = fts_pkg::FTS_RX_STAMP;
        end else if (can_load && rx_in_valid) begin
          d.od   = rx_in_data;
          d.ov   = 1'b1;
          d.of   = rx_in_first && !q.done;
          d.ol   = rx_in_last;
          d.done = 1'b0;
        end
      end
      fts_pkg::FTS_RX_STAMP: begin
        if (can_load) begin
          d.od  = q.sh[63:56];
          d.sh  = {q.sh[55:0], 8'h00};
          d.ov  = 1'b1;
          d.of  = 1'b0;
          d.ol  = 1'b0;
          d.cnt = q.cnt - 4'h1;
          if (q.cnt == 4'h1) begin
            d.st   = fts_pkg::FTS_RX_PASS;
            d.done = 1'b1;
          end
        end
      end
      default: begin
        d.st = fts_pkg::FTS_RX_PASS;
      end
    endcase
    // A new stamp wins over an acknowledge landing in the same cycle.
    if (tx_take_stamp) begin
      d.ts = stamp_now;
      d.tv = 1'b1;
    end else if (tx_stamp_ack) begin
      d.tv = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rx_in_ready = can_load && q.st == fts_pkg::FTS_RX_PASS
                       && !(rx_in_first && stamp_on && !q.done);
  assign rx_out_valid        = q.ov;
  assign rx_out_data         = q.od;
  assign rx_out_first        = q.of;
  assign rx_out_last         = q.ol;
  assign tx_stamp_valid      = q.tv;
  assign tx_stamp            = q.ts;
  assign free_count_snapshot = tif.snapshot;
  assign free_count          = tif.free;
  assign synt_seconds        = tif.sec;
  assign synt_nanoseconds    = tif.ns;

  property p_rx_prepend;
    @(posedge clock) disable iff (sys_rst)
      rx_take_stamp |-> !rx_in_ready ##1 (rx_out_valid && rx_out_first
                                          && rx_out_data == $past(stamp_aligned[63:56]));
  endproperty
  a_rx_prepend: assert property (p_rx_prepend) else $error("stamp not placed ahead of frame");

  property p_rx_short_len;
    @(posedge clock) disable iff (sys_rst)
      rx_take_stamp && !fts_pkg::fts_stamp_long(fmt) |=> q.cnt == 4'h3;
  endproperty
  a_rx_short_len: assert property (p_rx_short_len) else $error("short stamp length wrong");

  property p_rx_no_stamp;
    @(posedge clock) disable iff (sys_rst)
      q.st == fts_pkg::FTS_RX_PASS && !stamp_on |=> q.st == fts_pkg::FTS_RX_PASS;
  endproperty
  a_rx_no_stamp: assert property (p_rx_no_stamp) else $error("stamp inserted while disabled");

  property p_tx_only_req;
    @(posedge clock) disable iff (sys_rst)
      !tx_take_stamp |=> $stable(tx_stamp);
  endproperty
  a_tx_only_req: assert property (p_tx_only_req) else $error("tx stamp changed without request");

  property p_tx_need_enable;
    @(posedge clock) disable iff (sys_rst)
      $rose(tx_stamp_valid) |-> $past(frame_stamp_enable) && $past(counter_run_enable);
  endproperty
  a_tx_need_enable: assert property (p_tx_need_enable) else $error("tx stamp while disabled");

  property p_fmt_sec2;
    @(posedge clock) disable iff (sys_rst)
      tx_take_stamp && fmt == fts_pkg::FTS_FMT_SEC2_NS30 |=>
        tx_stamp == {32'h0000_0000, $past(tif.sec[1:0]), $past(tif.ns[29:0])};
  endproperty
  a_fmt_sec2: assert property (p_fmt_sec2) else $error("first format stamp wrong");

  property p_fmt_sec32;
    @(posedge clock) disable iff (sys_rst)
      tx_take_stamp && fmt == fts_pkg::FTS_FMT_SEC32_NS30 |=>
        tx_stamp == {$past(tif.sec), 2'h0, $past(tif.ns[29:0])};
  endproperty
  a_fmt_sec32: assert property (p_fmt_sec32) else $error("second format stamp wrong");

  property p_fmt_free;
    @(posedge clock) disable iff (sys_rst)
      tx_take_stamp && fmt == fts_pkg::FTS_FMT_FREE32 |=>
        tx_stamp == {32'h0000_0000, $past(tif.free)} && tx_stamp_valid;
  endproperty
  a_fmt_free: assert property (p_fmt_free) else $error("third format stamp wrong");

  // Stream checks: stamp bytes lead, then frame bytes pass through in order; transmit stamp valid checks follow.
  property p_rx_long_len;
    @(posedge clock) disable iff (sys_rst)
      rx_take_stamp && fts_pkg::fts_stamp_long(fmt) |=> q.cnt == 4'h7;
  endproperty
  a_rx_long_len: assert property (p_rx_long_len) else $error("long stamp length wrong");

  property p_long_top;
    @(posedge clock) disable iff (sys_rst)
      rx_take_stamp && fts_pkg::fts_stamp_long(fmt) |=> rx_out_data == $past(stamp_now[63:56]);
  endproperty
  a_long_top: assert property (p_long_top) else $error("long stamp top byte wrong");

  property p_short_top;
    @(posedge clock) disable iff (sys_rst)
      rx_take_stamp && !fts_pkg::fts_stamp_long(fmt) |=> rx_out_data == $past(stamp_now[31:24]);
  endproperty
  a_short_top: assert property (p_short_top) else $error("short stamp top byte wrong");

  property p_rx_stamp_bytes;
    @(posedge clock) disable iff (sys_rst)
      q.st == fts_pkg::FTS_RX_STAMP && can_load |=>
        rx_out_valid && !rx_out_first && rx_out_data == $past(q.sh[63:56]);
  endproperty
  a_rx_stamp_bytes: assert property (p_rx_stamp_bytes) else $error("stamp byte out of order");

  property p_rx_end_stamp;
    @(posedge clock) disable iff (sys_rst)
      q.st == fts_pkg::FTS_RX_STAMP && can_load && q.cnt == 4'h1 |=>
        q.st == fts_pkg::FTS_RX_PASS && q.done;
  endproperty
  a_rx_end_stamp: assert property (p_rx_end_stamp) else $error("stamp did not end");

  property p_rx_own_first;
    @(posedge clock) disable iff (sys_rst)
      q.done && rx_in_valid && rx_in_ready |=> rx_out_valid && !rx_out_first;
  endproperty
  a_rx_own_first: assert property (p_rx_own_first) else $error("frame byte marked first");

  property p_rx_pass_data;
    @(posedge clock) disable iff (sys_rst)
      q.st == fts_pkg::FTS_RX_PASS && rx_in_valid && rx_in_ready |=>
        rx_out_valid && rx_out_data == $past(rx_in_data) && rx_out_last == $past(rx_in_last);
  endproperty
  a_rx_pass_data: assert property (p_rx_pass_data) else $error("frame byte not passed");

  property p_rx_no_run;
    @(posedge clock) disable iff (sys_rst)
      q.st == fts_pkg::FTS_RX_PASS && !counter_run_enable |=> q.st == fts_pkg::FTS_RX_PASS;
  endproperty
  a_rx_no_run: assert property (p_rx_no_run) else $error("stamp inserted while stopped");

  // The spare format code sends a stamp of zeros.
  property p_fmt_zero;
    @(posedge clock) disable iff (sys_rst)
      rx_take_stamp && stamp_format == 2'h3 |=> rx_out_data == 8'h00 && rx_out_first;
  endproperty
  a_fmt_zero: assert property (p_fmt_zero) else $error("spare format stamp not zero");

  property p_tx_sticky;
    @(posedge clock) disable iff (sys_rst)
      tx_stamp_valid && !tx_stamp_ack |=> tx_stamp_valid;
  endproperty
  a_tx_sticky: assert property (p_tx_sticky) else $error("tx stamp valid dropped early");

  property p_tx_ack_clear;
    @(posedge clock) disable iff (sys_rst)
      tx_stamp_valid && tx_stamp_ack && !tx_take_stamp |=> !tx_stamp_valid;
  endproperty
  a_tx_ack_clear: assert property (p_tx_ack_clear) else $error("tx stamp valid not cleared");

  property p_tx_no_run;
    @(posedge clock) disable iff (sys_rst)
      !counter_run_enable |=> !$rose(tx_stamp_valid);
  endproperty
  a_tx_no_run: assert property (p_tx_no_run) else $error("tx stamp while stopped");

endmodule : fts_top

// [verif/fts_top_test.sv]
// Self-checking testbench for the frame time-stamp top.
`timescale 1ns/100ps
module fts_top_test;
  logic        clock;
  logic        sys_rst;
  logic        counter_run_enable;
  logic        frame_stamp_enable;
  logic [1:0]  stamp_format;
  logic [31:0] nanosecond_rollover_limit;
  logic        capture_strobe_input;
  logic [31:0] free_count_snapshot;
  logic [31:0] free_count;
  logic [31:0] synt_seconds;
  logic [31:0] synt_nanoseconds;
  logic        rx_in_valid;
  logic        rx_in_ready;
  logic [7:0]  rx_in_data;
  logic        rx_in_first;
  logic        rx_in_last;
  logic        rx_out_valid;
  logic        rx_out_ready;
  logic [7:0]  rx_out_data;
  logic        rx_out_first;
  logic        rx_out_last;
  logic        tx_frame_start;
  logic        tx_stamp_request;
  logic        tx_stamp_valid;
  logic [63:0] tx_stamp;
  logic        tx_stamp_ack;
  int          fail_count;
  int          samples_checked;

  fts_top fts_top_inst (
    .clock(clock), .sys_rst(sys_rst), .counter_run_enable(counter_run_enable),
    .frame_stamp_enable(frame_stamp_enable), .stamp_format(stamp_format),
    .nanosecond_rollover_limit(nanosecond_rollover_limit),
    .capture_strobe_input(capture_strobe_input), .free_count_snapshot(free_count_snapshot),
    .free_count(free_count), .synt_seconds(synt_seconds), .synt_nanoseconds(synt_nanoseconds),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data),
    .rx_in_first(rx_in_first), .rx_in_last(rx_in_last), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data), .rx_out_first(rx_out_first),
    .rx_out_last(rx_out_last), .tx_frame_start(tx_frame_start),
    .tx_stamp_request(tx_stamp_request), .tx_stamp_valid(tx_stamp_valid),
    .tx_stamp(tx_stamp), .tx_stamp_ack(tx_stamp_ack)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Stamp expected from the counters as they stand before the taking edge.
  function automatic logic [63:0] exp_stamp(input logic [1:0] f);
    case (f)
      2'h0:    return {32'h0000_0000, synt_seconds[1:0], synt_nanoseconds[29:0]};
      2'h1:    return {synt_seconds, 2'h0, synt_nanoseconds[29:0]};
      2'h2:    return {32'h0000_0000, free_count};
      default: return 64'h0000_0000_0000_0000;
    endcase
  endfunction : exp_stamp
  task automatic test_counters;
    logic [31:0] f0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk(free_count, 0);
    chk({synt_seconds, synt_nanoseconds}, 0);
    chk($bits(free_count), 32);
    @(posedge clock) counter_run_enable <= 1'b1;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk(synt_nanoseconds, 32'h0000_00c8);
    f0 = free_count;
    @(posedge clock);
    @(negedge clock);
    chk(synt_nanoseconds, 0);
    chk(synt_seconds, 1);
    repeat (24) @(posedge clock);
    @(negedge clock);
    chk(free_count - f0, 32'h0000_0078);
    @(posedge clock) counter_run_enable <= 1'b0;
    @(negedge clock);
    f0 = free_count;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk(free_count, f0);
    @(posedge clock) counter_run_enable <= 1'b1;
  endtask : test_counters

  task automatic test_snapshot;
    logic [31:0] e;
    @(posedge clock) capture_strobe_input <= 1'b1;
    @(negedge clock) e = free_count;
    @(posedge clock);
    @(negedge clock);
    chk(free_count_snapshot, e);
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk(free_count_snapshot, e);
    @(posedge clock) capture_strobe_input <= 1'b0;
    counter_run_enable <= 1'b0;
    @(posedge clock) capture_strobe_input <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(free_count_snapshot, e);
    @(posedge clock) capture_strobe_input <= 1'b0;
    counter_run_enable <= 1'b1;
  endtask : test_snapshot

  task automatic test_rx(input logic [1:0] f, input logic en);
    logic [7:0]  q[$];
    logic [63:0] st;
    logic        r;
    logic        first0;
    int          k1;
    int          k2;
    int          n;
    @(posedge clock) frame_stamp_enable <= en;
    stamp_format <= f;
    @(posedge clock);
    fork
      begin
        rx_in_valid <= 1'b1;
        rx_in_first <= 1'b1;
        rx_in_data  <= 8'ha5;
        @(negedge clock);
        st = exp_stamp(f);
        r = rx_in_ready;
        @(posedge clock);
        for (k1 = 0; !r && k1 < 50; k1++) begin
          @(negedge clock) r = rx_in_ready;
          @(posedge clock);
        end
        rx_in_first <= 1'b0;
        rx_in_last  <= 1'b1;
        rx_in_data  <= 8'h3c;
        r = 1'b0;
        for (k1 = 0; !r && k1 < 50; k1++) begin
          @(negedge clock) r = rx_in_ready;
          @(posedge clock);
        end
        rx_in_valid <= 1'b0;
        rx_in_last  <= 1'b0;
      end
      begin
        for (k2 = 0; k2 < 60; k2++) begin
          @(negedge clock);
          if (rx_out_valid === 1'b1) begin
            if (q.size() == 0)
              first0 = rx_out_first;
            q.push_back(rx_out_data);
            if (rx_out_last === 1'b1)
              break;
          end
        end
      end
    join
    n = !en ? 0 : (f == 2'h1) ? 8 : 4;
    chk(q.size(), n + 2);
    chk(first0, 1);
    for (int i = 0; i < n && i < q.size(); i++)
      chk(q[i], st[8*(n-1-i) +: 8]);
    if (q.size() == n + 2) begin
      chk(q[n], 8'ha5);
      chk(q[n+1], 8'h3c);
    end
  endtask : test_rx

  task automatic test_tx(input logic [1:0] f);
    logic [63:0] st;
    @(posedge clock) frame_stamp_enable <= 1'b1;
    stamp_format   <= f;
    tx_frame_start <= 1'b1;
    @(posedge clock) tx_frame_start <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(tx_stamp_valid, 0);
    @(posedge clock) tx_frame_start <= 1'b1;
    tx_stamp_request <= 1'b1;
    @(negedge clock) st = exp_stamp(f);
    @(posedge clock) tx_frame_start <= 1'b0;
    tx_stamp_request <= 1'b0;
    repeat (3) @(negedge clock);
    chk(tx_stamp_valid, 1);
    chk(tx_stamp, st);
    @(posedge clock) tx_stamp_ack <= 1'b1;
    @(posedge clock) tx_stamp_ack <= 1'b0;
    frame_stamp_enable <= 1'b0;
    @(negedge clock);
    chk(tx_stamp_valid, 0);
    @(posedge clock) tx_frame_start <= 1'b1;
    tx_stamp_request <= 1'b1;
    @(posedge clock) tx_frame_start <= 1'b0;
    tx_stamp_request <= 1'b0;
    repeat (2) @(negedge clock);
    chk(tx_stamp_valid, 0);
  endtask : test_tx

  initial begin
    #(40 * 6000);
    fail_count++;
    results();
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    counter_run_enable = 1'b0;
    frame_stamp_enable = 1'b0;
    stamp_format = 2'h0;
    nanosecond_rollover_limit = 32'h0000_00c8;
    capture_strobe_input = 1'b0;
    rx_in_valid = 1'b0;
    rx_in_data = 8'h00;
    rx_in_first = 1'b0;
    rx_in_last = 1'b0;
    rx_out_ready = 1'b1;
    tx_frame_start = 1'b0;
    tx_stamp_request = 1'b0;
    tx_stamp_ack = 1'b0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    test_counters();
    test_snapshot();
    for (int f = 0; f < 4; f++)
      test_rx(f[1:0], 1'b1);
    test_rx(2'h1, 1'b0);
    for (int f = 0; f < 3; f++)
      test_tx(f[1:0]);
    results();
  end
endmodule : fts_top_test
